//--- bus_controller_model.sv
// bus controller model that sends program strings
`timescale 1ns/100ps
module bus_controller_model (
	input logic clock, // system clock
	output logic [7:0] rx_data, // listener byte
	output logic rx_valid, // byte strobe
	output logic remote_line // remote enable line
);
	// idle bus at time zero
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'h0;
		remote_line = 1'h0;
	end
	// one byte per cycle, gap idle cycles after each
	// strings may carry values finer than 1 MHz steps
	task automatic send(input string s, input int gap, input logic r);
		int i;
		int j;
		for (i = 0; i < s.len(); i++) begin
			@(negedge clock);
			remote_line = r; // remote line up with data
			rx_data = s[i]; // mnemonic, value, suffix in order
			rx_valid = 1'h1;
			for (j = 0; j < gap; j++) begin
				@(negedge clock);
				rx_valid = 1'h0;
				rx_data = ~rx_data; // released data line
			end
		end
		@(negedge clock);
		rx_valid = 1'h0;
		rx_data = ~rx_data;
	endtask
endmodule

//--- decimal_accumulator.v
// free-field decimal value collector with megahertz rounding
`timescale 1ns/100ps
module decimal_accumulator (
	input wire clock, // system clock
	input wire rst, // synchronous reset, active high
	input wire clear, // start a new value
	input wire digit_valid, // one decimal digit arrives
	input wire [3:0] digit, // digit value 0..9
	input wire point, // decimal point arrives
	output wire [19:0] milli, // value times 1000, rounded
	output wire [19:0] whole // value rounded to an integer
);
	reg [16:0] int_q; // integer part
	reg [9:0] frac_q; // first three fraction digits
	reg [2:0] nfrac_q; // fraction digits seen, saturating
	reg point_q; // decimal point seen
	reg up_q; // fourth fraction digit rounds up
	reg half_q; // first fraction digit rounds up
	wire [26:0] scaled; // integer part times 1000

	assign scaled = int_q * 27'd1000;
	// round to nearest thousandth
	assign milli = scaled[19:0] + {10'h000, frac_q} + {19'h0_0000, up_q};
	assign whole = {3'h0, int_q} + {19'h0_0000, half_q};

	// digit collection, further fraction digits are dropped
	always @(posedge clock) begin
		if (rst || clear) begin
			int_q <= 17'h0_0000;
			frac_q <= 10'h000;
			nfrac_q <= 3'h0;
			point_q <= 1'b0;
			up_q <= 1'b0;
			half_q <= 1'b0;
		end else if (point) begin
			point_q <= 1'b1;
		end else if (digit_valid) begin
			if (!point_q) begin
				// integer digits shift in
				int_q <= int_q * 17'd10 + {13'h0000, digit};
			end else begin
				case (nfrac_q)
					3'h0: begin
						frac_q <= digit * 10'd100;
						half_q <= (digit >= 4'h5);
					end
					3'h1: frac_q <= frac_q + digit * 10'd10;
					3'h2: frac_q <= frac_q + {6'h00, digit};
					3'h3: up_q <= (digit >= 4'h5);
					default: up_q <= up_q;
				endcase
				if (nfrac_q != 3'h4) begin
					nfrac_q <= nfrac_q + 3'h1;
				end
			end
		end
	end
endmodule

//--- remote_command_frontend.v
// remote/local state machine and program string parser
`timescale 1ns/100ps
`include "remote_command_frontend_regs.vh"
module remote_command_frontend (
	input wire clock, // system clock
	input wire rst, // synchronous reset, active high
	input wire [7:0] rx_data, // listener data byte
	input wire rx_valid, // addressed byte strobe
	input wire remote_line, // bus remote enable line
	input wire go_to_local, // go-to-local bus command pulse
	input wire lockout_cmd, // local lockout bus command pulse
	input wire key_valid, // front-panel key strobe
	input wire [4:0] key_code, // front-panel key code
	input wire local_key, // local key strobe
	output reg remote_indicator, // remote lamp
	output reg panel_enable, // panel changes accepted
	output reg panel_key_valid, // gated key strobe
	output reg [4:0] panel_key_code, // gated key code
	output reg sweep_fixed, // fixed-frequency mode
	output reg [19:0] fixed_mhz, // fixed frequency in MHz
	output reg [19:0] start_mhz, // sweep start in MHz
	output reg [19:0] stop_mhz, // sweep stop in MHz
	output reg [19:0] sweep_time_ms, // sweep time in ms
	output reg marker_load, // marker update pulse
	output reg [3:0] marker_num, // marker number
	output reg [19:0] marker_mhz, // marker frequency in MHz
	output reg square_am_on, // square-wave modulation on
	output reg preset_done, // preset applied pulse
	output reg cmd_error // malformed command pulse
);
	// lamp is lit in both remote and lockout
	// remote states, one-hot
	localparam R_LOCAL = 3'b001;
	localparam R_REMOTE = 3'b010;
	localparam R_LOCK = 3'b100;
	// parser states, one-hot
	localparam P_IDLE = 5'b00001; // awaiting mnemonic
	localparam P_MNEM = 5'b00010; // second mnemonic letter
	localparam P_MOD = 5'b00100; // modulation digit
	localparam P_VAL = 5'b01000; // collecting value
	localparam P_SUF = 5'b10000; // second suffix letter

	reg [2:0] rs_q; // remote state
	reg [2:0] rs_d;
	// lockout sent while local waits for the next remote entry
	reg armed_q; // lockout requested
	reg armed_d;
	reg [4:0] ps_q; // parser state
	reg [7:0] first_q; // first letter held
	reg [2:0] cmd_q; // command awaiting value
	reg acc_clear; // accumulator controls
	reg acc_digit;
	reg acc_point;
	wire accept; // byte taken from bus
	wire [19:0] val_milli; // value times 1000
	wire [19:0] val_whole; // rounded integer value

	// digit test
	function is_digit;
		input [7:0] c;
		begin
			is_digit = (c >= `CH_0) && (c <= `CH_9);
		end
	endfunction

	// letter test
	function is_letter;
		input [7:0] c;
		begin
			is_letter = (c >= `CH_A) && (c <= `CH_Z);
		end
	endfunction

	// only addressed data with the remote line taken
	// bytes with the remote line low leave no trace
	assign accept = rx_valid && remote_line;

	// remote state next value
	// go-to-local outranks every other event, then lockout, then data
	// lamp follows rs_d, so it lights at the edge that takes the byte
	always @* begin
		rs_d = rs_q;
		armed_d = armed_q;
		if (go_to_local || (local_key && rs_q == R_REMOTE)) begin
			// local key same as go-to-local
			rs_d = R_LOCAL;
			armed_d = 1'b0;
		end else if (lockout_cmd) begin
			// lockout is remembered even while still local
			armed_d = 1'b1;
			if (rs_q != R_LOCAL || accept) begin
				// a byte in the same cycle still leaves local
				rs_d = R_LOCK;
			end
		end else if (accept && rs_q == R_LOCAL) begin
			// enter remote before data is handled
			rs_d = armed_q ? R_LOCK : R_REMOTE;
		end else begin
			// local key in lockout falls through unchanged
			rs_d = rs_q;
		end
	end

	// remote state and lamp
	always @(posedge clock) begin
		if (rst) begin
			// power-on: local, panel live
			rs_q <= R_LOCAL;
			armed_q <= 1'b0;
			remote_indicator <= 1'b0;
			panel_enable <= 1'b1;
		end else begin
			// lamp and panel follow the next state directly
			rs_q <= rs_d;
			armed_q <= armed_d;
			remote_indicator <= (rs_d != R_LOCAL);
			panel_enable <= (rs_d == R_LOCAL);
		end
	end

	// accumulator steering
	always @* begin
		acc_clear = 1'b0;
		acc_digit = 1'b0;
		acc_point = 1'b0;
		// only taken bytes steer the collector
		if (accept) begin
			case (ps_q)
				// a new mnemonic starts a fresh value
				P_IDLE: acc_clear = 1'b1;
				P_MNEM: acc_clear = 1'b1;
				P_VAL: begin
					// digits and point gathered
					acc_digit = is_digit(rx_data);
					acc_point = (rx_data == `CH_POINT);
				end
				// suffix and modulation bytes leave the value alone
				default: acc_clear = 1'b0;
			endcase
		end
	end

	// one value collector serves every command
	decimal_accumulator value_acc (
		.clock(clock),
		.rst(rst),
		.clear(acc_clear),
		.digit_valid(acc_digit),
		.digit(rx_data[3:0]),
		.point(acc_point),
		.milli(val_milli),
		.whole(val_whole)
	);

	// parser, execution and panel gating
	// one byte per cycle; a key and a byte in one cycle both act
	// values beyond 20 bits, or integer parts beyond 17 bits, wrap; nothing saturates
	always @(posedge clock) begin
		if (rst) begin
			// power-on preset: start/stop sweep, modulation off
			ps_q <= P_IDLE;
			first_q <= 8'h00;
			cmd_q <= `CMD_NONE;
			panel_key_valid <= 1'b0;
			panel_key_code <= 5'h00;
			sweep_fixed <= 1'b0;
			fixed_mhz <= `PRESET_START_MHZ;
			start_mhz <= `PRESET_START_MHZ;
			stop_mhz <= `PRESET_STOP_MHZ;
			sweep_time_ms <= `PRESET_TIME_MS;
			marker_load <= 1'b0;
			marker_num <= 4'h0;
			marker_mhz <= 20'h0_0000;
			square_am_on <= 1'b0;
			preset_done <= 1'b0;
			cmd_error <= 1'b0;
		end else begin
			// pulses default low
			panel_key_valid <= 1'b0;
			marker_load <= 1'b0;
			preset_done <= 1'b0;
			cmd_error <= 1'b0;
			// panel keys pass only in local
			// keys are dropped silently outside local
			if (key_valid && rs_q == R_LOCAL) begin
				if (key_code == `KEY_PRESET) begin
					// preset key loads the preset sweep
					sweep_fixed <= 1'b0;
					start_mhz <= `PRESET_START_MHZ;
					stop_mhz <= `PRESET_STOP_MHZ;
					sweep_time_ms <= `PRESET_TIME_MS;
					square_am_on <= 1'b0;
					preset_done <= 1'b1;
				end else begin
					// other keys go on to the panel logic
					panel_key_valid <= 1'b1;
					panel_key_code <= key_code;
				end
			end
			// one byte per cycle, in order
			if (accept) begin
				case (ps_q)
					P_IDLE: begin
						// separators between commands skipped
						if (is_letter(rx_data)) begin
							// first mnemonic letter held
							first_q <= rx_data;
							ps_q <= P_MNEM;
						end
					end
					P_MNEM: begin
						// second letter picks the command, a value follows
						ps_q <= P_VAL;
						if (first_q == `CH_I && rx_data == `CH_P) begin
							// preset state
							sweep_fixed <= 1'b0;
							start_mhz <= `PRESET_START_MHZ;
							stop_mhz <= `PRESET_STOP_MHZ;
							sweep_time_ms <= `PRESET_TIME_MS;
							square_am_on <= 1'b0;
							preset_done <= 1'b1;
							ps_q <= P_IDLE;
						end else if (first_q == `CH_C && rx_data == `CH_W) begin
							// fixed frequency, gigahertz value
							cmd_q <= `CMD_FIXED;
						end else if (first_q == `CH_F && rx_data == `CH_A) begin
							// sweep start, gigahertz value
							cmd_q <= `CMD_START;
						end else if (first_q == `CH_F && rx_data == `CH_B) begin
							// sweep stop, gigahertz value
							cmd_q <= `CMD_STOP;
						end else if (first_q == `CH_S && rx_data == `CH_T) begin
							// sweep time, millisecond value
							cmd_q <= `CMD_TIME;
						end else if (first_q == `CH_M && rx_data == `CH_D) begin
							// modulation takes one more digit
							cmd_q <= `CMD_AM;
							ps_q <= P_MOD;
						end else if (first_q == `CH_M && is_digit(rx_data)) begin
							// single-digit marker number
							cmd_q <= `CMD_MARKER;
							marker_num <= rx_data[3:0];
						end else begin
							// unknown mnemonic: flag it, back to idle
							cmd_error <= 1'b1;
							ps_q <= P_IDLE;
						end
					end
					P_MOD: begin
						// square-wave modulation on
						if (rx_data == `CH_1) begin
							square_am_on <= 1'b1;
						end else begin
							// only modulation one is known
							cmd_error <= 1'b1;
						end
						ps_q <= P_IDLE;
					end
					P_VAL: begin
						// first suffix letter ends the value
						if (is_letter(rx_data)) begin
							// suffix letter held, value frozen
							first_q <= rx_data;
							ps_q <= P_SUF;
						end
					end
					P_SUF: begin
						// the suffix ends the command either way
						ps_q <= P_IDLE;
						if (first_q == `CH_G && rx_data == `CH_Z) begin
							// gigahertz values land in MHz
							case (cmd_q)
								`CMD_FIXED: begin
									// fixed mode replaces the preset sweep
									fixed_mhz <= val_milli;
									sweep_fixed <= 1'b1;
								end
								`CMD_START: start_mhz <= val_milli;
								`CMD_STOP: stop_mhz <= val_milli;
								`CMD_MARKER: begin
									// marker number came with the mnemonic
									marker_mhz <= val_milli;
									marker_load <= 1'b1;
								end
								// gigahertz after a time command
								default: cmd_error <= 1'b1;
							endcase
						end else if (first_q == `CH_M && rx_data == `CH_S
							&& cmd_q == `CMD_TIME) begin
							// whole milliseconds, half rounds up
							sweep_time_ms <= val_whole;
						end else begin
							// wrong suffix: nothing committed
							cmd_error <= 1'b1;
						end
					end
					// no other state is reachable
					default: ps_q <= P_IDLE;
				endcase
			end
		end
	end
endmodule

//--- remote_command_frontend_regs.vh
// constants for the remote command front end
// Summary of operation
// - remote: indicator lit, panel keys except local ignored
// - local key in remote returns to local
// - lockout: indicator lit, panel and local key ignored
// - go-to-local clears remote and lockout states
// - addressed data with remote line enters remote first
// - local key acts like go-to-local in remote only, ignored in lockout
// - preset command loads start/stop sweep preset state
// - fixed-frequency command, gigahertz value, gigahertz suffix
// - concatenated commands with free-field fractional values accepted
// - frequency kept with three fractional gigahertz digits
// - finer than one megahertz rounds to nearest
// - start and stop frequency commands in gigahertz
// - sweep-time command in milliseconds with millisecond suffix
// - marker command: digit number then gigahertz frequency
// - square-wave modulation command enables internal modulation
`ifndef REMOTE_COMMAND_FRONTEND_REGS_VH
`define REMOTE_COMMAND_FRONTEND_REGS_VH

// ascii characters of the program language
`define CH_A 8'h41
`define CH_B 8'h42
`define CH_C 8'h43
`define CH_D 8'h44
`define CH_F 8'h46
`define CH_G 8'h47
`define CH_I 8'h49
`define CH_M 8'h4D
`define CH_P 8'h50
`define CH_S 8'h53
`define CH_T 8'h54
`define CH_W 8'h57
`define CH_Z 8'h5A
`define CH_0 8'h30
`define CH_1 8'h31
`define CH_9 8'h39
`define CH_POINT 8'h2E

// command codes held while a value is collected
`define CMD_NONE 3'h0
`define CMD_FIXED 3'h1
`define CMD_START 3'h2
`define CMD_STOP 3'h3
`define CMD_TIME 3'h4
`define CMD_MARKER 3'h5
`define CMD_AM 3'h6

// front-panel key code of the preset key
`define KEY_PRESET 5'h01

// preset state values, in megahertz and milliseconds
`define PRESET_START_MHZ 20'h0_07D0
`define PRESET_STOP_MHZ 20'h0_4E20
`define PRESET_TIME_MS 20'h0_000A

`endif

//--- remote_frontend_properties.sv
// assertions on the remote command front end ports
`timescale 1ns/100ps
module remote_frontend_properties (
	input logic clock, // system clock
	input logic rst, // synchronous reset
	input logic [7:0] rx_data, // listener byte
	input logic rx_valid, // byte strobe
	input logic remote_line, // remote enable
	input logic go_to_local, // go-to-local pulse
	input logic key_valid, // key strobe
	input logic [4:0] key_code, // key code
	input logic local_key, // local key strobe
	input logic remote_indicator, // remote lamp
	input logic panel_enable, // panel accepted
	input logic panel_key_valid, // forwarded key
	input logic [4:0] panel_key_code, // forwarded code
	input logic sweep_fixed, // fixed mode
	input logic preset_done // preset pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_byte_remote: assert property (
		rx_valid && remote_line && !go_to_local && !local_key |=> remote_indicator)
		else $error("byte did not set remote");
	a_gtl_local: assert property (
		go_to_local |=> !remote_indicator && panel_enable)
		else $error("go-to-local not local");
	a_lamp_panel: assert property (
		remote_indicator != panel_enable)
		else $error("lamp and panel agree");
	a_remote_gate: assert property (
		!panel_enable |=> !panel_key_valid)
		else $error("key passed in remote");
	a_key_pass: assert property (
		panel_enable && key_valid && key_code != 5'h01
		|=> panel_key_valid && panel_key_code == $past(key_code))
		else $error("key not forwarded");
	a_preset_key: assert property (
		panel_enable && key_valid && key_code == 5'h01 && !rx_valid
		|=> preset_done && !sweep_fixed)
		else $error("panel preset missing");
	a_lamp_drop: assert property (
		$fell(remote_indicator) |-> $past(go_to_local) || $past(local_key))
		else $error("lamp dropped alone");
	a_lamp_hold: assert property (
		remote_indicator && !go_to_local && !local_key |=> remote_indicator)
		else $error("lamp dropped");
	a_fixed_suffix: assert property (
		$rose(sweep_fixed) |-> $past(rx_valid) && $past(rx_data) == 8'h5A)
		else $error("fixed mode without suffix");
	c_key: cover property (panel_key_valid);
	c_fixed: cover property ($rose(sweep_fixed));
	c_drop: cover property ($fell(remote_indicator));
endmodule
bind remote_command_frontend remote_frontend_properties chk_i (
	.clock(clock),
	.rst(rst),
	.rx_data(rx_data),
	.rx_valid(rx_valid),
	.remote_line(remote_line),
	.go_to_local(go_to_local),
	.key_valid(key_valid),
	.key_code(key_code),
	.local_key(local_key),
	.remote_indicator(remote_indicator),
	.panel_enable(panel_enable),
	.panel_key_valid(panel_key_valid),
	.panel_key_code(panel_key_code),
	.sweep_fixed(sweep_fixed),
	.preset_done(preset_done)
);

//--- tb.sv
// self-checking bench for the remote command front end
`timescale 1ns/100ps
module tb;
	logic clock, rst, go_to_local, lockout_cmd, key_valid, local_key; // stimulus
	logic rx_valid, remote_line; // from controller model
	logic [7:0] rx_data; // program byte
	logic [4:0] key_code, panel_key_code; // key codes
	logic remote_indicator, panel_enable, panel_key_valid, sweep_fixed; // state
	logic marker_load, square_am_on, preset_done, cmd_error, sf_q; // pulses
	logic [3:0] marker_num; // marker number
	logic [19:0] fixed_mhz, start_mhz, stop_mhz, sweep_time_ms, marker_mhz; // values
	logic [27:0] notes[$]; // expected results, kind in top nibble
	logic [31:0] rnd = 32'hcb1b_a452; // random state
	int bad_count = 0; // mismatches
	int compares = 0; // comparisons
	int i; // loop index
	remote_command_frontend dut (
		.clock(clock),
		.rst(rst),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.remote_line(remote_line),
		.go_to_local(go_to_local),
		.lockout_cmd(lockout_cmd),
		.key_valid(key_valid),
		.key_code(key_code),
		.local_key(local_key),
		.remote_indicator(remote_indicator),
		.panel_enable(panel_enable),
		.panel_key_valid(panel_key_valid),
		.panel_key_code(panel_key_code),
		.sweep_fixed(sweep_fixed),
		.fixed_mhz(fixed_mhz),
		.start_mhz(start_mhz),
		.stop_mhz(stop_mhz),
		.sweep_time_ms(sweep_time_ms),
		.marker_load(marker_load),
		.marker_num(marker_num),
		.marker_mhz(marker_mhz),
		.square_am_on(square_am_on),
		.preset_done(preset_done),
		.cmd_error(cmd_error)
	);
	bus_controller_model ctl (
		.clock(clock),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.remote_line(remote_line)
	);
	// 200 MHz clock
	initial clock = 1'h0;
	always #2.5 clock = ~clock;
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [27:0] e, input logic [27:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// oldest note against what appeared
	task automatic take(input string n, input logic [27:0] g);
		if (notes.size() == 0) chk(n, 28'hfff_ffff, g);
		else chk(n, notes.pop_front(), g);
	endtask
	// watcher of pulses and fixed-mode entry
	always @(negedge clock) begin
		sf_q <= sweep_fixed;
		if (!rst) begin
			if (preset_done === 1'h1) take("preset", {8'h10, start_mhz});
			if (marker_load === 1'h1) take("marker", {4'h2, marker_num, marker_mhz});
			if (cmd_error === 1'h1) take("error", 28'h300_0000);
			if (panel_key_valid === 1'h1) take("key", {4'h5, 19'h0, panel_key_code});
			if (sweep_fixed === 1'h1 && sf_q === 1'h0) take("fixed", {8'h40, fixed_mhz});
		end
	end
	// panel and bus command strobes, one cycle
	task automatic ev(input logic kv, input logic [4:0] c, input logic lk, gl, lo);
		@(negedge clock);
		key_valid = kv;
		key_code = c;
		local_key = lk;
		go_to_local = gl;
		lockout_cmd = lo;
		@(negedge clock);
		{key_valid, local_key, go_to_local, lockout_cmd} = 4'h0;
		@(negedge clock);
	endtask
	// string sent promptly or slowly
	task automatic sd(input string s, input logic r);
		rnd = lfsr(rnd);
		ctl.send(s, rnd[1:0] == 2'h0 ? 2 : 0, r);
		repeat (2) @(negedge clock);
	endtask
	task automatic st(input logic e);
		chk("state", e ? 28'h000_0001 : 28'h000_0002, {26'h0, panel_enable, remote_indicator});
	endtask
	// main sequence
	initial begin
		{rst, go_to_local, lockout_cmd, key_valid, local_key} = 5'h10;
		key_code = 5'h00;
		repeat (20) @(negedge clock);
		rst = 1'h0;
		st(1'h0);
		rnd = lfsr(rnd);
		notes.push_back({4'h5, 19'h0, rnd[4:0] | 5'h02});
		ev(1'h1, rnd[4:0] | 5'h02, 1'h0, 1'h0, 1'h0);
		notes.push_back(28'h100_07D0);
		notes.push_back(28'h400_1D83);
		sd("IPCW7.555GZ", 1'h1);
		st(1'h1);
		ev(1'h1, 5'h01, 1'h0, 1'h0, 1'h0);
		ev(1'h0, 5'h00, 1'h1, 1'h0, 1'h0);
		st(1'h0);
		notes.push_back(28'h100_07D0);
		notes.push_back(28'h400_0C46);
		sd("IP CW3.14159GZ", 1'h1);
		notes.push_back(28'h100_07D0);
		notes.push_back(28'h400_04D2);
		sd("IPCW1.2344GZ", 1'h1);
		ev(1'h0, 5'h00, 1'h0, 1'h0, 1'h1);
		sd("FA3GZFB7GZ", 1'h1);
		chk("start", 20'h0_0BB8, start_mhz);
		chk("stop", 20'h0_1B58, stop_mhz);
		ev(1'h1, 5'h01, 1'h1, 1'h0, 1'h0);
		st(1'h1);
		ev(1'h0, 5'h00, 1'h0, 1'h1, 1'h0);
		st(1'h0);
		notes.push_back(28'h100_07D0);
		ev(1'h1, 5'h01, 1'h0, 1'h0, 1'h0);
		ev(1'h0, 5'h00, 1'h0, 1'h0, 1'h1);
		sd("ST50MS", 1'h1);
		ev(1'h0, 5'h00, 1'h1, 1'h0, 1'h0);
		st(1'h1);
		chk("time", 20'h0_0032, sweep_time_ms);
		notes.push_back(28'h210_0FA0);
		sd("M14GZ", 1'h1);
		sd("MD1", 1'h1);
		chk("am", 1'h1, square_am_on);
		notes.push_back(28'h300_0000);
		sd("CW5MS", 1'h1);
		sd("CW9GZ", 1'h0);
		chk("fixed", 20'h0_04D2, fixed_mhz);
		for (i = 0; i < 50 && notes.size() > 0; i++) @(negedge clock);
		if (notes.size() > 0) chk("pending", 28'h000_0000, notes.size());
		tally_and_finish;
	end
endmodule
